// >>> hw/step_comm_map.svh
// offsets, field positions, reset values and timing counts
// assumes a 40 MHz ref_clk and a byte-addressed register port
`ifndef STEP_COMM_MAP_SVH
`define STEP_COMM_MAP_SVH
`define A_CTRL    8'h00
`define A_MTYPE   8'h04
`define A_ZVOLT   8'h08
`define A_CYCLE   8'h0C
`define A_PHASE   8'h10
`define A_PDIST   8'h14
`define A_MARG    8'h18
`define A_SLEW    8'h1C
`define A_SMOOTH  8'h20
`define A_KD      8'h24
`define A_KP      8'h28
`define A_KI      8'h2C
`define A_CPOS0   8'h30
`define A_SCNT0   8'h34
`define A_CPOS1   8'h38
`define A_SCNT1   8'h3C
`define A_ENC     8'h40
`define A_PERR    8'h44
`define A_AUX0    8'h48
`define A_AUX1    8'h4C
`define A_STAT    8'h50
`define C_ZP      0
`define C_CAL     1
`define C_KIND    3:2
`define C_AXIS    4
`define C_STOP    5
`define KD_MAX    16'h0FFF
`define KP_MAX    16'h03FF
`define KS_MIN    5'h01
`define KS_MAX    5'h10
`define KS_RST    5'h02
`define MT_STEP_HI 8'h02
`define MT_STEP_LO 8'hFE
`define MT_RST    8'h01
`define CYCLE_RST 24'h000FA0
`define SLEW_RST  16'h03E8
`define START_HP  16'h2710
`define LVL_HI    16'h7FFF
`define LVL_LO    16'h8000
`define CLK_HZ    40000000
`define ZP_HOLD_MS 100
`define ZP_HOLD_CYC (`ZP_HOLD_MS * (`CLK_HZ / 1000))
`endif

// >>> hw/step_comm_pkg.sv
// types shared by the axis logic
// assumes step_comm_map.svh for numbers
package step_comm_pkg;
  typedef enum logic [1:0]
  {
    OP_IDLE     = 2'b00,
    OP_ZP_DRIVE = 2'b01,
    OP_ZP_DONE  = 2'b10
  } op_type;
  typedef enum logic [1:0]
  {
    MV_NONE = 2'b00,
    MV_REL  = 2'b01,
    MV_ABS  = 2'b10,
    MV_JOG  = 2'b11
  } move_kind_type;
  typedef struct packed
  {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;
  typedef struct packed
  {
    logic [15:0] analog_cmd_terminal;
    logic [15:0] second_analog_terminal;
    logic        error_terminal;
    logic        drive_enable_terminal;
  } term_type;
  typedef struct packed
  {
    op_type           op;
    logic [31:0]      zp_cnt;
    logic             servo_on;
    logic [15:0]      zv;
    logic [23:0]      cycle;
    logic [23:0]      phase;
    logic             est_done;
    logic             cal_armed;
    logic [2:0]       sect;
    logic [1:0]       enc_ab;
    logic [1:0][1:0]  aux_ab;
    logic [31:0]      enc_pos;
    logic [1:0][31:0] aux_pos;
    logic [1:0][31:0] cpos;
    logic [1:0][31:0] tpos;
    logic [1:0]       moving;
    logic [1:0]       jog;
    logic [1:0]       dir;
    logic [1:0]       lvl;
    logic [1:0]       first;
    logic [1:0][15:0] cur;
    logic [1:0][15:0] tmr;
    logic [1:0][7:0]  mtype;
    logic [31:0]      marg;
    logic [15:0]      slew;
    logic [15:0]      kd;
    logic [15:0]      kp;
    logic [15:0]      ki;
    logic [4:0]       ks;
    logic [31:0]      rdata;
    term_type         term;
  } state_type;
endpackage : step_comm_pkg

// >>> hw/axis_step_comm.sv
// commutation set-up and step/direction generation for two axes
// assumes encoder, hall and jumper inputs already synchronous to ref_clk
// Function
// R1 - zero-phase command pulls motor to zero phase, then clears phase
// R2 - signed voltage argument sets the drive level during that pull
// R3 - positive argument ends with the drive switched off
// R4 - negative argument ends servo enabled, holding present position
// R5 - hall code gives a coarse phase at reset, within 30 degrees
// R6 - phase distance reads encoder counts from zero phase to here
// R7 - armed hall calibration loads phase on first hall transition
// R8 - hall transitions taken as exactly 60 electrical degrees apart
// R9 - step pulses have equal high and low time
// R10 - stepper axis withdraws its auxiliary encoder counter
// R11 - commanded step position and encoder position are readable
// R12 - smoothing accepts 0.5 to 8, 8 smoothing most
// R13 - profiler uses slew speed and smoothing for all move kinds
// R14 - stepper axis runs open loop, position error reads zero
// R15 - motor type 2 gives active high steps, -2 active low
// R16 - each axis enters stepper mode only with its own jumper
// R17 - first axis step on analog terminal, direction on second one
// R18 - second axis step on error terminal, direction on enable
// R19 - damping gain limited to 4095
// R20 - proportional gain limited to 1023
// R21 - operator keeps proportional gain at most damping gain over 4
// R22 - direction settles before the first step; one step per count
`include "step_comm_map.svh"
module axis_step_comm #(
  parameter logic [31:0] ZP_HOLD_CYC = `ZP_HOLD_CYC
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire step_comm_pkg::bus_req_type bus,
  output logic [31:0]                    rdata,
  input  wire logic [2:0]                hall,
  input  wire logic [1:0]                enc_ab,
  input  wire logic [1:0]                aux0_ab,
  input  wire logic [1:0]                aux1_ab,
  input  wire logic                      first_axis_stepper_jumper,
  input  wire logic                      second_axis_stepper_jumper,
  output step_comm_pkg::term_type        term
);
  import step_comm_pkg::*;

  state_type s_q;
  state_type s_d;
  logic [1:0] stp;
  logic [2:0] hs;
  logic [1:0] eq;
  logic [1:0][1:0] aux_in;

  // ==========================================================
  // helpers
  function automatic logic [1:0] quad(input logic [1:0] p,
                                      input logic [1:0] c);
    logic [3:0] k;
    k = {p, c};
    unique case (k)
      4'b0001, 4'b0111, 4'b1110, 4'b1000: quad = 2'b01;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: quad = 2'b11;
      default: quad = 2'b00;
    endcase
  endfunction : quad

  function automatic logic [31:0] bump(input logic [31:0] v,
                                       input logic [1:0] d);
    bump = v;
    if (d == 2'b01)
      bump = v + 32'h1;
    else if (d == 2'b11)
      bump = v - 32'h1;
  endfunction : bump

  // invalid codes 000 and 111 map to 7
  function automatic logic [2:0] sector(input logic [2:0] h);
    unique case (h)
      3'b001: sector = 3'h0;
      3'b011: sector = 3'h1;
      3'b010: sector = 3'h2;
      3'b110: sector = 3'h3;
      3'b100: sector = 3'h4;
      3'b101: sector = 3'h5;
      default: sector = 3'h7;
    endcase
  endfunction : sector

  // n twelfths of a magnetic cycle; 341/4096 stands for 1/12
  function automatic logic [23:0] frac12(input logic [23:0] cyc,
                                         input logic [3:0] n);
    logic [39:0] p;
    p = 40'(cyc) * 40'(n) * 40'h155;
    frac12 = p[35:12];
  endfunction : frac12

  function automatic logic [2:0] ks_shift(input logic [4:0] ks);
    if (ks >= 5'h10)
      ks_shift = 3'h4;
    else if (ks >= 5'h08)
      ks_shift = 3'h3;
    else if (ks >= 5'h04)
      ks_shift = 3'h2;
    else if (ks >= 5'h02)
      ks_shift = 3'h1;
    else
      ks_shift = 3'h0;
  endfunction : ks_shift

  // half period glides toward the slew value, never below it
  function automatic logic [15:0] ramp(input logic [15:0] c,
                                       input logic [15:0] sl,
                                       input logic [2:0] sh);
    logic [15:0] gap;
    gap = (c > sl) ? ((c - sl) >> sh) : 16'h0;
    ramp = (gap == 16'h0) ? sl : c - gap;
  endfunction : ramp

  function automatic logic [15:0] lvl(input logic b);
    lvl = b ? `LVL_HI : `LVL_LO;
  endfunction : lvl

  function automatic logic [15:0] mag(input logic [15:0] v);
    mag = v[15] ? 16'(-v) : v;
  endfunction : mag

  function automatic logic [15:0] clamp(input logic [31:0] v,
                                        input logic [15:0] mx);
    clamp = (v > 32'(mx)) ? mx : v[15:0];
  endfunction : clamp

  // ==========================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = '0;
    aux_in[0] = aux0_ab;
    aux_in[1] = aux1_ab;
    stp[0] = first_axis_stepper_jumper &&                     // R16
             (s_q.mtype[0] == `MT_STEP_HI ||
              s_q.mtype[0] == `MT_STEP_LO);
    stp[1] = second_axis_stepper_jumper &&                    // R16
             (s_q.mtype[1] == `MT_STEP_HI ||
              s_q.mtype[1] == `MT_STEP_LO);

    eq = quad(s_q.enc_ab, enc_ab);
    s_d.enc_ab = enc_ab;
    s_d.enc_pos = bump(s_q.enc_pos, eq);                        // R11
    for (int i = 0; i < 2; i++)
    begin
      s_d.aux_ab[i] = aux_in[i];
      if (stp[i])
        s_d.aux_pos[i] = '0;                                    // R10
      else
        s_d.aux_pos[i] = bump(s_q.aux_pos[i],
                              quad(s_q.aux_ab[i], aux_in[i]));
    end

    // phase follows the encoder inside one magnetic cycle
    if (eq == 2'b01)
      s_d.phase = (s_q.phase >= s_q.cycle - 24'h1) ? '0
                  : s_q.phase + 24'h1;
    else if (eq == 2'b11)
      s_d.phase = (s_q.phase == 24'h0) ? s_q.cycle - 24'h1
                  : s_q.phase - 24'h1;
    hs = sector(hall);
    if (!s_q.est_done && hs != 3'h7)
    begin
      // sector midpoint keeps the error under half a sector
      s_d.phase = frac12(s_q.cycle, {hs, 1'b1});                // R5
      s_d.est_done = 1'b1;
    end
    else if (s_q.cal_armed && hs != 3'h7 && s_q.sect != 3'h7 &&
             hs != s_q.sect)
    begin
      // boundary between sectors is a whole multiple of 60 degrees
      if (hs == ((s_q.sect == 3'h5) ? 3'h0 : s_q.sect + 3'h1))
        s_d.phase = frac12(s_q.cycle, {hs, 1'b0});              // R8
      else
        s_d.phase = frac12(s_q.cycle, {s_q.sect, 1'b0});        // R8
      s_d.cal_armed = 1'b0;                                     // R7
    end
    if (hs != 3'h7)
      s_d.sect = hs;

    // ========================================================
    // zero-phase sequence
    unique case (s_q.op)
      OP_IDLE:
      begin
      end
      OP_ZP_DRIVE:
      begin
        if (s_q.zp_cnt == 32'h0)
          s_d.op = OP_ZP_DONE;
        else
          s_d.zp_cnt = s_q.zp_cnt - 32'h1;
      end
      OP_ZP_DONE:
      begin
        s_d.phase = '0;                                         // R1
        s_d.servo_on = s_q.zv[15];                              // R3 R4
        s_d.cpos[0] = s_q.enc_pos;                              // R4
        s_d.tpos[0] = s_q.enc_pos;
        s_d.op = OP_IDLE;
      end
      default:
        s_d.op = OP_IDLE;
    endcase

    // ========================================================
    // step generators
    for (int i = 0; i < 2; i++)
    begin
      if (s_q.moving[i])
      begin
        if (s_q.tmr[i] != 16'h0)
          s_d.tmr[i] = s_q.tmr[i] - 16'h1;
        else if (s_q.first[i])
        begin
          s_d.first[i] = 1'b0;                                  // R22
          s_d.tmr[i] = s_q.cur[i];
        end
        else if (s_q.lvl[i])
        begin
          s_d.lvl[i] = 1'b0;                                    // R9
          s_d.tmr[i] = s_q.cur[i];
        end
        else if (s_q.jog[i] || s_q.cpos[i] != s_q.tpos[i])
        begin
          s_d.lvl[i] = 1'b1;
          s_d.cpos[i] = bump(s_q.cpos[i],                       // R22
                             s_q.dir[i] ? 2'b11 : 2'b01);
          s_d.cur[i] = ramp(s_q.cur[i], s_q.slew,               // R13
                            ks_shift(s_q.ks));
          s_d.tmr[i] = s_d.cur[i];                              // R9
        end
        else
          s_d.moving[i] = 1'b0;
      end
      if (!stp[i])
      begin
        s_d.moving[i] = 1'b0;
        s_d.lvl[i] = 1'b0;
      end
    end

    // ========================================================
    // register writes
    if (bus.wr)
    begin
      unique case (bus.addr)
        `A_CTRL:
        begin
          if (bus.wdata[`C_ZP] && !stp[0])
          begin
            s_d.op = OP_ZP_DRIVE;                               // R1
            s_d.zp_cnt = ZP_HOLD_CYC - 32'h1;
            s_d.servo_on = 1'b0;
          end
          if (bus.wdata[`C_CAL])
            s_d.cal_armed = 1'b1;                               // R7
          for (int i = 0; i < 2; i++)
          begin
            if (bus.wdata[`C_AXIS] == i[0] && stp[i])
            begin
              if (bus.wdata[`C_KIND] != MV_NONE)
              begin
                unique case (bus.wdata[`C_KIND])
                  MV_REL: s_d.tpos[i] = s_d.cpos[i] + s_q.marg;
                  MV_ABS: s_d.tpos[i] = s_q.marg;
                  default: s_d.tpos[i] = s_d.cpos[i];
                endcase
                s_d.jog[i] = (bus.wdata[`C_KIND] == MV_JOG);
                s_d.dir[i] = s_d.jog[i] ? s_q.marg[31] :        // R22
                  ($signed(s_d.tpos[i]) < $signed(s_d.cpos[i]));
                s_d.moving[i] = 1'b1;                           // R13
                s_d.first[i] = 1'b1;
                s_d.lvl[i] = 1'b0;
                s_d.cur[i] = `START_HP;
                s_d.tmr[i] = `START_HP;
              end
              if (bus.wdata[`C_STOP])
              begin
                // stop lands after the pulse now in flight
                s_d.jog[i] = 1'b0;
                s_d.tpos[i] = s_d.cpos[i];
              end
            end
          end
        end
        `A_MTYPE:
        begin
          s_d.mtype[0] = bus.wdata[7:0];                        // R15
          s_d.mtype[1] = bus.wdata[15:8];
        end
        `A_ZVOLT:  s_d.zv = bus.wdata[15:0];                    // R2
        `A_CYCLE:
          if (bus.wdata[23:0] != 24'h0)
            s_d.cycle = bus.wdata[23:0];
        `A_PHASE:  s_d.phase = bus.wdata[23:0];
        `A_MARG:   s_d.marg = bus.wdata;
        `A_SLEW:
          s_d.slew = (bus.wdata[15:0] == 16'h0) ? 16'h1
                     : bus.wdata[15:0];
        `A_SMOOTH:
          s_d.ks = (bus.wdata < 32'(`KS_MIN)) ? `KS_MIN :       // R12
                   5'(clamp(bus.wdata, 16'(`KS_MAX)));
        `A_KD:     s_d.kd = clamp(bus.wdata, `KD_MAX);          // R19
        `A_KP:     s_d.kp = clamp(bus.wdata, `KP_MAX);          // R20
        `A_KI:     s_d.ki = bus.wdata[15:0];
        default:
        begin
        end
      endcase
    end

    // ========================================================
    // register reads, valid in the following cycle only
    if (bus.rd)
    begin
      unique case (bus.addr)
        `A_MTYPE:  s_d.rdata = {16'h0, s_q.mtype[1], s_q.mtype[0]};
        `A_ZVOLT:  s_d.rdata = {16'h0, s_q.zv};
        `A_CYCLE:  s_d.rdata = {8'h0, s_q.cycle};
        `A_PHASE:  s_d.rdata = {8'h0, s_q.phase};
        `A_PDIST:                                               // R6
          s_d.rdata = (s_q.phase > (s_q.cycle >> 1))
                      ? 32'(s_q.phase) - 32'(s_q.cycle)
                      : 32'(s_q.phase);
        `A_MARG:   s_d.rdata = s_q.marg;
        `A_SLEW:   s_d.rdata = {16'h0, s_q.slew};
        `A_SMOOTH: s_d.rdata = {27'h0, s_q.ks};
        `A_KD:     s_d.rdata = {16'h0, s_q.kd};
        `A_KP:     s_d.rdata = {16'h0, s_q.kp};
        `A_KI:     s_d.rdata = {16'h0, s_q.ki};
        `A_CPOS0, `A_SCNT0: s_d.rdata = s_q.cpos[0];            // R11
        `A_CPOS1, `A_SCNT1: s_d.rdata = s_q.cpos[1];            // R11
        `A_ENC:    s_d.rdata = s_q.enc_pos;                     // R11
        `A_PERR:                                                // R14
          s_d.rdata = stp[0] ? 32'h0 : s_q.cpos[0] - s_q.enc_pos;
        `A_AUX0:   s_d.rdata = s_q.aux_pos[0];
        `A_AUX1:   s_d.rdata = s_q.aux_pos[1];
        `A_STAT:
          s_d.rdata = {23'h0, s_q.cal_armed, s_q.est_done,
                       s_q.op, s_q.servo_on, s_q.moving, stp};
        default:   s_d.rdata = '0;
      endcase
    end

    // ========================================================
    // terminal mapping
    if (stp[0])
    begin
      s_d.term.analog_cmd_terminal =                            // R17
        lvl(s_d.lvl[0] ^ s_q.mtype[0][7]);                      // R15
      s_d.term.second_analog_terminal = lvl(s_d.dir[0]);        // R17
    end
    else
    begin
      // phase A carries the pull, phase B stays at zero
      s_d.term.analog_cmd_terminal =
        (s_d.op == OP_ZP_DRIVE) ? mag(s_d.zv) : 16'h0;          // R2
      s_d.term.second_analog_terminal = 16'h0;
    end
    if (stp[1])
    begin
      s_d.term.error_terminal = s_d.lvl[1] ^ s_q.mtype[1][7];   // R18
      s_d.term.drive_enable_terminal = s_d.dir[1];              // R18
    end
    else
    begin
      s_d.term.error_terminal = 1'b0;
      s_d.term.drive_enable_terminal =
        s_d.servo_on || (s_d.op == OP_ZP_DRIVE);                // R3
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.sect <= 3'h7;
      s_q.cycle <= `CYCLE_RST;
      s_q.mtype <= {`MT_RST, `MT_RST};
      s_q.slew <= `SLEW_RST;
      s_q.ks <= `KS_RST;
      s_q.cur <= {`START_HP, `START_HP};
    end
    else
      s_q <= s_d;
  end

  assign rdata = s_q.rdata;
  assign term = s_q.term;

  // ==========================================================
  // checks
  logic [16:0] hi_len;
  logic [16:0] lo_len;
  logic [16:0] hi_rec;
  logic        had;
  logic        lvl_p;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_len <= '0;
      lo_len <= '0;
      hi_rec <= '0;
      had <= 1'b0;
      lvl_p <= 1'b0;
    end
    else
    begin
      lvl_p <= s_q.lvl[0];
      hi_len <= s_q.lvl[0] ? hi_len + 17'h1 : 17'h0;
      lo_len <= (!s_q.lvl[0] && s_q.moving[0] && !s_q.first[0])
                ? lo_len + 17'h1 : 17'h0;
      if (lvl_p && !s_q.lvl[0])
      begin
        hi_rec <= hi_len;
        had <= 1'b1;
      end
      if (!s_q.moving[0])
        had <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_zp_phase_zero: assert property ((s_q.op == OP_ZP_DONE) |=> // R1
    (s_q.phase == 24'h0) && (s_q.op == OP_IDLE))
    else $error("phase not cleared after zero-phase pull");
  a_zp_drive_level: assert property ((s_q.op == OP_ZP_DRIVE) // R2
    ##1 (s_q.op == OP_ZP_DRIVE) |->
    term.analog_cmd_terminal == mag(s_q.zv) || $past(stp[0]))
    else $error("pull level differs from voltage argument");
  a_zp_end_off: assert property ((s_q.op == OP_ZP_DONE && // R3
    !s_q.zv[15]) |=> !s_q.servo_on ##1 !term.drive_enable_terminal
    || $past(stp[1]))
    else $error("positive argument left drive on");
  a_zp_end_on: assert property ((s_q.op == OP_ZP_DONE && // R4
    s_q.zv[15]) |=> s_q.servo_on && s_q.cpos[0] == $past(s_q.enc_pos))
    else $error("negative argument did not hold position");
  a_hall_coarse: assert property ((!s_q.est_done && // R5
    sector(hall) != 3'h7) |=> s_q.est_done &&
    s_q.phase == frac12($past(s_q.cycle), {$past(sector(hall)), 1'b1}))
    else $error("coarse phase not loaded from hall code");
  a_cal_once: assert property ((s_q.cal_armed && // R7
    sector(hall) != 3'h7 && s_q.sect != 3'h7 &&
    sector(hall) != s_q.sect && s_q.est_done && !bus.wr) |=>
    !s_q.cal_armed)
    else $error("calibration stayed armed past a transition");
  a_step_half: assert property ((s_q.lvl[0] && !lvl_p && had) // R9
    |-> lo_len == hi_rec)
    else $error("step low time differs from high time");
  a_aux_hold: assert property (stp[0] |=> s_q.aux_pos[0] == 32'h0) // R10
    else $error("aux counter runs on a stepper axis");
  a_open_loop: assert property ((bus.rd && bus.addr == `A_PERR && // R14
    stp[0]) |=> rdata == 32'h0)
    else $error("position error reported on stepper axis");
  a_step_pol: assert property (($past(stp[0]) && !s_q.lvl[0]) // R15
    |-> term.analog_cmd_terminal ==
        ($past(s_q.mtype[0][7]) ? `LVL_HI : `LVL_LO))
    else $error("idle step level has wrong polarity");
  a_gain_limit: assert property (s_q.kd <= `KD_MAX && // R19 R20
    s_q.kp <= `KP_MAX)
    else $error("gain above its limit");
  a_step_count: assert property ($rose(s_q.lvl[0]) |-> // R22
    $stable(s_q.dir[0]) && (s_q.cpos[0] - $past(s_q.cpos[0]) ==
    (s_q.dir[0] ? 32'hFFFFFFFF : 32'h1)))
    else $error("step without one count in set direction");

  c_zp_done: cover property (s_q.op == OP_ZP_DONE ##1
    s_q.servo_on);
  c_hall_cal: cover property ($fell(s_q.cal_armed));
  c_move_end: cover property ($fell(s_q.moving[0]) && !s_q.jog[0]);
  c_jog_dual: cover property (s_q.jog[1] && s_q.lvl[1]);
endmodule : axis_step_comm

// >>> testbench/motor_model.sv
// encoder model that follows axis0 step and direction levels
// assumes axis0 is a stepper with active high pulses when it moves
`include "step_comm_map.svh"
module motor_model
  import step_comm_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire step_comm_pkg::term_type term,
  output logic [1:0]                   enc_ab
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  logic       hi_q;
  // gray order 00 01 11 10 counts up
  assign enc_ab = {cnt_q[1], cnt_q[1] ^ cnt_q[0]};
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 2'h0;
      hi_q  <= 1'b0;
    end
    else
    begin
      hi_q <= (term.analog_cmd_terminal == `LVL_HI);
      if (term.analog_cmd_terminal == `LVL_HI && !hi_q)
        cnt_q <= (term.second_analog_terminal == `LVL_HI) ?
                 cnt_q - 2'h1 : cnt_q + 2'h1;
    end
  end
endmodule : motor_model

// >>> testbench/test_axis_step_comm.sv
// self-checking bench for the two-axis step and commutation block
// assumes motor_model closes the encoder loop for axis0
`include "step_comm_map.svh"
module test_axis_step_comm;
  timeunit 1ns;
  timeprecision 1ps;
  import step_comm_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  bus_req_type bus = '0;
  logic [31:0] rdata;
  logic [2:0]  hall = 3'h1;
  logic [1:0]  enc_ab;
  logic [1:0]  aux0_ab = 2'h0;
  logic        jmp0 = 1'b0;
  logic        jmp1 = 1'b0;
  term_type    term;
  logic [31:0] v;
  logic        hi_q = 1'b0;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n_rise = 0;
  // a short pull keeps the zero-phase test brief
  axis_step_comm #(.ZP_HOLD_CYC(32'h14)) dut (.ref_clk(ref_clk),
    .rst_n(rst_n), .bus(bus), .rdata(rdata), .hall(hall),
    .enc_ab(enc_ab), .aux0_ab(aux0_ab), .aux1_ab(2'h0),
    .first_axis_stepper_jumper(jmp0),
    .second_axis_stepper_jumper(jmp1), .term(term));
  motor_model motor (.ref_clk(ref_clk), .rst_n(rst_n), .term(term),
    .enc_ab(enc_ab));
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    hi_q <= (term.analog_cmd_terminal === `LVL_HI);
    if (term.analog_cmd_terminal === `LVL_HI && !hi_q)
      n_rise++;
    if (cyc == 90000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    check(v, e);
  endtask : rdchk
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle
  // polls status until both axes stop; bounded by the timeout
  task automatic wait_idle();
    for (int i = 0; i < 30000; i++)
    begin
      rd(`A_STAT);
      if (v[3:2] === 2'h0)
        break;
    end
  endtask : wait_idle
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rdchk(`A_MTYPE, 32'h101);
    rdchk(`A_SMOOTH, 32'h2);
    rdchk(`A_SLEW, 32'h3E8);
    rdchk(`A_CYCLE, 32'hFA0);
    rdchk(`A_PHASE, 32'h14D);
    rdchk(8'h60, 32'h0);
    rd(`A_STAT);
    check(v[7], 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_gains();
    wr(`A_KD, 32'h1000);
    rdchk(`A_KD, 32'hFFF);
    wr(`A_KD, 32'hFFF);
    rdchk(`A_KD, 32'hFFF);
    wr(`A_KP, 32'h400);
    rdchk(`A_KP, 32'h3FF);
    wr(`A_SMOOTH, 32'h0);
    rdchk(`A_SMOOTH, 32'h1);
    wr(`A_SMOOTH, 32'h20);
    rdchk(`A_SMOOTH, 32'h10);
    $display("test gains done");
  endtask : t_gains
  task automatic t_cal();
    wr(`A_CTRL, 32'h2);
    rd(`A_STAT);
    check(v[8], 1'b1);
    @(posedge ref_clk);
    hall <= 3'h3;
    settle();
    rd(`A_STAT);
    check(v[8], 1'b0);
    rdchk(`A_PHASE, 32'h29A);
    $display("test hall calibration done");
  endtask : t_cal
  task automatic t_zp(input logic [15:0] zv, input logic on);
    wr(`A_ZVOLT, {16'h0, zv});
    wr(`A_CTRL, 32'h1);
    settle();
    check(term.analog_cmd_terminal, 16'h10);
    check(term.drive_enable_terminal, 1'b1);
    repeat (30) @(posedge ref_clk);
    rdchk(`A_PHASE, 32'h0);
    rdchk(`A_PDIST, 32'h0);
    rd(`A_STAT);
    check(v[4], on);
    check(term.drive_enable_terminal, on);
    check(term.analog_cmd_terminal, 16'h0);
    $display("test zero phase done");
  endtask : t_zp
  task automatic t_step0();
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    wr(`A_MTYPE, 32'h102);
    settle();
    check(term.analog_cmd_terminal, 16'h0);
    @(posedge ref_clk);
    jmp0 <= 1'b1;
    aux0_ab <= 2'h1;
    settle();
    @(posedge ref_clk);
    aux0_ab <= 2'h3;
    check(term.analog_cmd_terminal, `LVL_LO);
    rdchk(`A_AUX0, 32'h0);
    // least smoothing jumps to slew at the first step and keeps runs short
    wr(`A_SMOOTH, 32'h1);
    wr(`A_SLEW, 32'h4);
    wr(`A_MARG, 32'h3);
    wr(`A_CTRL, 32'h4);
    settle();
    check(term.second_analog_terminal, `LVL_LO);
    for (int i = 0; i < 30000 && term.analog_cmd_terminal !== `LVL_HI; i++)
      @(posedge ref_clk);
    while (term.analog_cmd_terminal === `LVL_HI && hi < 12000)
    begin
      @(posedge ref_clk);
      hi++;
    end
    while (term.analog_cmd_terminal === `LVL_LO && lo < 12000)
    begin
      @(posedge ref_clk);
      lo++;
    end
    check(hi, lo);
    wait_idle();
    check(n_rise, 3);
    rdchk(`A_CPOS0, 32'h3);
    rdchk(`A_SCNT0, 32'h3);
    rdchk(`A_ENC, 32'h3);
    rdchk(`A_PERR, 32'h0);
    $display("test axis0 stepper done");
  endtask : t_step0
  task automatic t_step1();
    wr(`A_MTYPE, 32'hFE02);
    settle();
    check(term.error_terminal, 1'b0);
    @(posedge ref_clk);
    jmp1 <= 1'b1;
    settle();
    check(term.error_terminal, 1'b1);
    wr(`A_MARG, 32'h1);
    wr(`A_CTRL, 32'h18);
    settle();
    check(term.drive_enable_terminal, 1'b0);
    for (int i = 0; i < 30000 && term.error_terminal !== 1'b0; i++)
      @(posedge ref_clk);
    check(term.error_terminal, 1'b0);
    wait_idle();
    rdchk(`A_CPOS1, 32'h1);
    $display("test axis1 stepper done");
  endtask : t_step1
  // ==========================================================
  // closing report
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_gains();
    t_cal();
    t_zp(16'hFFF0, 1'b1);
    t_zp(16'h0010, 1'b0);
    t_step0();
    t_step1();
    end_of_test();
  end
endmodule : test_axis_step_comm
